// *** hdl/ifs_pkg.sv ***
// package: constants, types and register map of the instruction fetch sequencer
package ifs_pkg;
	localparam int         CLK_NS    = 8;
	localparam int         PH_N      = 8;
	localparam int         CYC_NS_S  = 2000;
	localparam int         CYC_NS_M  = 2250;
	localparam int         CYC_NS_L  = 4000;
	localparam logic [7:0] PH_LEN_S  = 8'(CYC_NS_S / (PH_N * CLK_NS));
	localparam logic [7:0] PH_LEN_M  = 8'(CYC_NS_M / (PH_N * CLK_NS));
	localparam logic [7:0] PH_LEN_L  = 8'(CYC_NS_L / (PH_N * CLK_NS));
	localparam logic [2:0] PH_ADR    = 3'h0;
	localparam logic [2:0] PH_RD     = 3'h1;
	localparam logic [2:0] PH_CAP    = 3'h2;
	localparam logic [2:0] PH_BASE   = 3'h3;
	localparam logic [2:0] PH_WB     = 3'h4;
	localparam logic [2:0] PH_ADD    = 3'h5;
	localparam logic [2:0] PH_LATE   = 3'h6;
	localparam logic [2:0] PH_LAST   = 3'h7;
	localparam logic [7:0] TIM_A_MSK = 8'hf0;
	localparam logic [7:0] TIM_B_MSK = 8'hcc;
	localparam logic [7:0] TIM_C_MSK = 8'haa;
	localparam logic [4:0] OP_LD     = 5'h18;
	localparam logic [4:0] OP_LDS    = 5'h04;
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_STAT    = 8'h04;
	localparam logic [7:0] A_IAR     = 8'h08;
	localparam logic [7:0] A_ACC     = 8'h0c;
	localparam logic [7:0] A_EXT     = 8'h10;
	localparam logic [7:0] A_TMP     = 8'h14;
	localparam logic [7:0] A_SAR     = 8'h18;
	localparam logic [7:0] A_BUF     = 8'h1c;
	localparam logic [7:0] A_FACT    = 8'h20;
	localparam logic [7:0] A_DEC     = 8'h24;
	localparam logic [7:0] A_XR1     = 8'h28;
	localparam logic [7:0] A_XR2     = 8'h2c;
	localparam logic [7:0] A_XR3     = 8'h30;
	localparam logic [7:0] A_STEP    = 8'h34;
	localparam logic [7:0] A_XFER    = 8'h38;
	localparam int         X_A2Q     = 0;
	localparam int         X_Q2A     = 1;
	localparam int         X_A2U     = 2;
	localparam int         X_U2A     = 3;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_I1   = 5'b00010,
		S_I2   = 5'b00100,
		S_IA   = 5'b01000,
		S_E1   = 5'b10000
	} ifs_seq_t;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ifs_mem_t;
	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} ifs_tim_t;
	typedef struct packed {
		ifs_seq_t        seq;
		logic [2:0]      phase;
		logic [7:0]      div;
		logic            run;
		logic            chan_sel;
		logic            chan_run;
		logic [1:0]      cyc_sel;
		logic [15:0]     iar;
		logic [15:0]     acc;
		logic [15:0]     ext;
		logic [15:0]     tmp;
		logic [15:0]     sar;
		logic [15:0]     buf_w;
		logic [15:0]     fact;
		logic [2:0][15:0] index_reg;
		logic [4:0]      opcode_reg;
		logic            fmt;
		logic [1:0]      tag;
		logic            ind;
		logic            bo;
		logic [1:0]      carry_overflow_flags;
		logic [5:0]      step;
		logic            ack;
		logic [31:0]     dat;
		logic            mem_rd;
		logic            mem_wr;
		logic [7:0]      phase_oh;
		ifs_tim_t        tim;
	} ifs_st_t;
endpackage : ifs_pkg

// *** hdl/ifs_seq.sv ***
// instruction fetch and effective address sequencer with wishbone register access
//
// The address map and the Wishbone slave port were chosen for this implementation.
module ifs_seq import ifs_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [15:0] mem_rdata_i,
	output ifs_mem_t         mem_o,
	output logic      [7:0]  phase_o,
	output logic             phase_zero_pulse_o,
	output logic             phase_seven_pulse_o,
	output ifs_tim_t         chan_tim_o,
	output logic             proc_clk_run_o,
	output logic             chan_clk_run_o,
	output logic      [1:0]  carry_overflow_flags_o
);
	ifs_st_t s;
	ifs_st_t n;

	function automatic logic [15:0] wmask(input logic [15:0] o, input logic [31:0] d, input logic [3:0] sel);
		wmask = {sel[1] ? d[15:8] : o[15:8], sel[0] ? d[7:0] : o[7:0]};
	endfunction : wmask

	function automatic logic [7:0] ph_len(input logic [1:0] c);
		unique case (c)
			2'h0:    ph_len = PH_LEN_S;
			2'h1:    ph_len = PH_LEN_M;
			default: ph_len = PH_LEN_L;
		endcase
	endfunction : ph_len

	// tag 0 picks the next-instruction address
	function automatic logic [15:0] base(input ifs_st_t t);
		if (t.tag == 2'h0) begin
			base = t.iar;
		end else begin
			base = t.index_reg[t.tag - 2'h1];
		end
	endfunction : base

	function automatic logic has_exec(input logic [4:0] op);
		has_exec = (op == OP_LD);
	endfunction : has_exec

	logic            acc_req;
	logic            ph_en;
	logic            extend;
	logic            cpu;
	logic [15:0]     rd_val;
	ifs_seq_t        after;

	always_comb begin
		n       = s;
		acc_req = wb_cyc_i && wb_stb_i;
		ph_en   = 1'b0;
		extend  = 1'b0;
		cpu     = !s.chan_run;
		rd_val  = 16'h0000;
		after   = S_I1;
		n.ack   = 1'b0;

		// bus slave: ack one cycle after request, write lands on the ack edge
		unique case (wb_adr_i)
			A_CTRL:  rd_val = {12'h000, s.cyc_sel, s.chan_sel, s.run};
			A_STAT:  rd_val = {1'b0, s.step != 6'h00, s.carry_overflow_flags, 1'b0,
			                   s.phase, 3'h0, s.seq};
			A_IAR:   rd_val = s.iar;
			A_ACC:   rd_val = s.acc;
			A_EXT:   rd_val = s.ext;
			A_TMP:   rd_val = s.tmp;
			A_SAR:   rd_val = s.sar;
			A_BUF:   rd_val = s.buf_w;
			A_FACT:  rd_val = s.fact;
			A_DEC:   rd_val = {s.opcode_reg, s.fmt, s.tag, s.ind, s.bo, 6'h00};
			A_XR1:   rd_val = s.index_reg[0];
			A_XR2:   rd_val = s.index_reg[1];
			A_XR3:   rd_val = s.index_reg[2];
			A_STEP:  rd_val = {10'h000, s.step};
			default: rd_val = 16'h0000;
		endcase
		if (acc_req && !s.ack) begin
			n.ack = 1'b1;
			n.dat = {16'h0000, rd_val};
		end
		if (acc_req && s.ack && wb_we_i) begin
			unique case (wb_adr_i)
				A_CTRL: begin
					if (wb_sel_i[0]) begin
						n.run      = wb_dat_i[0];
						n.chan_sel = wb_dat_i[1];
						n.cyc_sel  = wb_dat_i[3:2];
					end
				end
				A_IAR:  n.iar          = wmask(s.iar, wb_dat_i, wb_sel_i);
				A_ACC:  n.acc          = wmask(s.acc, wb_dat_i, wb_sel_i);
				A_EXT:  n.ext          = wmask(s.ext, wb_dat_i, wb_sel_i);
				A_XR1:  n.index_reg[0] = wmask(s.index_reg[0], wb_dat_i, wb_sel_i);
				A_XR2:  n.index_reg[1] = wmask(s.index_reg[1], wb_dat_i, wb_sel_i);
				A_XR3:  n.index_reg[2] = wmask(s.index_reg[2], wb_dat_i, wb_sel_i);
				A_STEP: begin
					if (wb_sel_i[0]) begin
						n.step = wb_dat_i[5:0];
					end
				end
				A_XFER: begin
					if (wb_sel_i[0]) begin
						if (wb_dat_i[X_A2Q]) begin
							n.ext = s.acc;
						end
						if (wb_dat_i[X_Q2A]) begin
							n.acc = s.ext;
						end
						if (wb_dat_i[X_A2U]) begin
							n.tmp = s.acc;
						end
						if (wb_dat_i[X_U2A]) begin
							n.acc = s.tmp;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// sequencer: the machine's own updates below win over software writes
		if (!s.run) begin
			n.seq   = S_IDLE;
			n.phase = PH_ADR;
			n.div   = 8'h00;
		end else if (s.seq == S_IDLE) begin
			n.seq      = S_I1;
			n.chan_run = s.chan_sel;
		end else begin
			ph_en = (s.div == ph_len(s.cyc_sel) - 8'h01);
			n.div = ph_en ? 8'h00 : s.div + 8'h01;
		end

		if (ph_en && cpu) begin
			// buffer capture is common to every storage cycle
			if (s.phase == PH_CAP) begin
				n.buf_w = mem_rdata_i;
			end
			unique case (s.seq)
				S_I1: begin
					unique case (s.phase)
						PH_ADR: begin
							n.sar = s.iar;
							n.iar = s.iar + 16'h0001;
							n.tmp = s.acc;
						end
						PH_CAP: begin
							n.opcode_reg = mem_rdata_i[15:11];
							n.fmt        = mem_rdata_i[10];
							n.tag        = mem_rdata_i[9:8];
							n.ind        = mem_rdata_i[7];
							n.bo         = mem_rdata_i[6];
							n.fact       = {{8{mem_rdata_i[7]}}, mem_rdata_i[7:0]};
						end
						PH_BASE: n.acc = base(s);
						PH_ADD: begin
							// long format leaves base and factor unused here
							if (!s.fmt) begin
								n.acc = s.acc + s.fact;
							end
						end
						PH_LATE: begin
							if (s.opcode_reg == OP_LDS) begin
								n.carry_overflow_flags = s.buf_w[1:0];
							end
						end
						default: begin
						end
					endcase
				end
				S_I2: begin
					unique case (s.phase)
						PH_ADR: begin
							n.sar = s.iar;
							n.iar = s.iar + 16'h0001;
						end
						PH_BASE: n.fact = s.buf_w;
						PH_ADD: begin
							if (s.tag != 2'h0) begin
								n.acc = s.acc + s.fact;
							end else begin
								n.acc = s.fact;
							end
						end
						default: begin
						end
					endcase
				end
				S_IA, S_E1: begin
					unique case (s.phase)
						PH_ADR:  n.sar  = s.acc;
						PH_BASE: n.fact = s.buf_w;
						PH_ADD:  n.acc  = s.fact;
						default: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		// next cycle type, decided at the end of phase 7
		unique case (s.seq)
			S_I1: begin
				if (s.fmt) begin
					after = S_I2;
				end else if (has_exec(s.opcode_reg)) begin
					after = S_E1;
				end else begin
					after = S_I1;
				end
			end
			S_I2: begin
				if (s.ind) begin
					after = S_IA;
				end else if (has_exec(s.opcode_reg)) begin
					after = S_E1;
				end else begin
					after = S_I1;
				end
			end
			// the fetched word is always direct, never another indirect pass
			S_IA: after = has_exec(s.opcode_reg) ? S_E1 : S_I1;
			default: after = S_I1;
		endcase

		if (ph_en) begin
			extend = (s.phase == PH_LAST) && (s.step != 6'h00);
			if (extend) begin
				// each held step shifts the accumulator low bit into the extension
				n.step = s.step - 6'h01;
				n.acc  = {1'b0, s.acc[15:1]};
				n.ext  = {s.acc[0], s.ext[15:1]};
			end else begin
				n.phase = s.phase + 3'h1;
				if (s.phase == PH_LAST) begin
					// clock choice only switches at a cycle boundary
					n.chan_run = s.chan_sel;
					if (cpu) begin
						n.seq = after;
					end
				end
			end
		end

		// storage strobes as levels for the whole phase
		n.mem_rd   = n.run && n.seq != S_IDLE && !n.chan_run && n.phase == PH_RD;
		n.mem_wr   = n.run && n.seq != S_IDLE && !n.chan_run && n.phase == PH_WB;
		n.phase_oh = n.run ? (8'h01 << n.phase) : 8'h00;
		n.tim.a    = |(n.phase_oh & TIM_A_MSK);
		n.tim.b    = |(n.phase_oh & TIM_B_MSK);
		n.tim.c    = |(n.phase_oh & TIM_C_MSK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s     <= '0;
			s.seq <= S_IDLE; // all-zero is no legal state code
		end else begin
			s <= n;
		end
	end

	assign wb_dat_o               = s.dat;
	assign wb_ack_o               = s.ack;
	assign mem_o.rd               = s.mem_rd;
	assign mem_o.wr               = s.mem_wr;
	assign mem_o.addr             = s.sar;
	assign mem_o.wdata            = s.buf_w;
	assign phase_o                = s.phase_oh;
	assign phase_zero_pulse_o     = s.phase_oh[0];
	assign phase_seven_pulse_o    = s.phase_oh[7];
	assign chan_tim_o             = s.tim;
	assign proc_clk_run_o         = s.run && !s.chan_run;
	assign chan_clk_run_o         = s.run && s.chan_run;
	assign carry_overflow_flags_o = s.carry_overflow_flags;
endmodule : ifs_seq

// *** sim/ifs_mem_model.sv ***
// partner: core storage with destructive read and write-back
module ifs_mem_model import ifs_pkg::*; (
	input  wire logic       clk_i,
	input  wire ifs_mem_t   mem_i,
	input  wire logic [5:0] delay_i,
	output logic     [15:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] words [256];
	logic [15:0] held = 16'h0000;
	logic [5:0]  cnt = 6'h00;
	logic        busy = 1'b0;
	logic        live = 1'b0;
	initial rdata_o = 16'h0000;
	initial foreach (words[i]) words[i] = 16'h0000;
	// read clears the core word: a missing write-back loses it
	always @(posedge clk_i) begin
		if (mem_i.rd && !busy) begin
			held <= words[mem_i.addr[7:0]];
			words[mem_i.addr[7:0]] <= 16'h0000;
			busy <= 1'b1;
			cnt <= 6'h00;
		end else if (busy && !live) begin
			cnt <= cnt + 6'h01;
			live <= (cnt >= delay_i);
		end
		if (mem_i.wr) begin
			words[mem_i.addr[7:0]] <= mem_i.wdata;
			busy <= 1'b0;
			live <= 1'b0;
		end
		// no valid word: toggling pattern, never a stale value
		rdata_o <= live ? held : ~rdata_o;
	end
endmodule : ifs_mem_model

// *** sim/ifs_seq_assertions.sv ***
// checker: port assertions of the fetch sequencer
module ifs_chk import ifs_pkg::*; (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire ifs_mem_t   mem_o,
	input wire logic [7:0] phase_o,
	input wire logic       phase_zero_pulse_o,
	input wire logic       phase_seven_pulse_o,
	input wire ifs_tim_t   chan_tim_o,
	input wire logic       proc_clk_run_o,
	input wire logic       chan_clk_run_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_rd_phase: assert property (mem_o.rd |-> phase_o[1] && proc_clk_run_o)
		else $error("read strobe outside phase one");
	chk_wr_phase: assert property (mem_o.wr |-> phase_o[4])
		else $error("write strobe outside phase four");
	chk_wr_hold: assert property ($rose(mem_o.wr) |=> ($stable(mem_o.addr) && $stable(mem_o.wdata))[*8])
		else $error("write-back address or data moved");
	chk_rd_addr: assert property ($rose(mem_o.rd) |=> ($stable(mem_o.addr))[*8])
		else $error("address moved during read strobe");
	chk_phase_step: assert property (|phase_o && |$past(phase_o) && phase_o != $past(phase_o)
		|-> phase_o == {$past(phase_o[6:0]), $past(phase_o[7])}) else $error("phase skipped");
	chk_phase_pulse: assert property (phase_zero_pulse_o == phase_o[0] && phase_seven_pulse_o == phase_o[7])
		else $error("phase pulse mismatch");
	chk_one_clock: assert property (!(proc_clk_run_o && chan_clk_run_o))
		else $error("both clocks running");
	chk_chan_quiet: assert property (chan_clk_run_o |-> !mem_o.rd && !mem_o.wr)
		else $error("storage strobe on channel clock");
	chk_tim_decode: assert property (|phase_o |-> chan_tim_o == {|(phase_o & TIM_A_MSK),
		|(phase_o & TIM_B_MSK), |(phase_o & TIM_C_MSK)}) else $error("channel timing decode wrong");
endmodule : ifs_chk

bind ifs_seq ifs_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .mem_o(mem_o), .phase_o(phase_o), .phase_zero_pulse_o(phase_zero_pulse_o),
	.phase_seven_pulse_o(phase_seven_pulse_o), .chan_tim_o(chan_tim_o), .proc_clk_run_o(proc_clk_run_o),
	.chan_clk_run_o(chan_clk_run_o));

// *** sim/ifs_seq_bench.sv ***
// bench: fetch sequencer instruction table and corner cases
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module ifs_seq_bench import ifs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] w0, w1, ia, w2, acc, iar; int n;} ifs_row_t;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h00000000;
	logic [5:0]  dly = 6'h00;
	logic [31:0] dat_o, q;
	logic [15:0] rdata;
	logic [7:0]  ph;
	logic [1:0]  flags;
	logic        ack, p0, p7, prun, crun;
	logic        p0_q = 1'b0;
	ifs_mem_t    mem;
	int          err_total = 0, total_checks = 0, n, clk_n = 0, p0_cnt = 0, p0_t = 0, p0_dt = 0;
	int          p7_run = 0, p7_len = 0;
	ifs_row_t    rows [8] = '{
		'{16'h0805, 16'h0000, 16'h0030, 16'h7777, 16'h0016, 16'h0011, 1},
		'{16'h0afe, 16'h0000, 16'h0030, 16'h7777, 16'h01fe, 16'h0011, 1},
		'{16'h0c00, 16'h0040, 16'h0030, 16'h7777, 16'h0040, 16'h0012, 2},
		'{16'h0d00, 16'h0040, 16'h0030, 16'h7777, 16'h0140, 16'h0012, 2},
		'{16'h0c80, 16'h0050, 16'h0050, 16'h00a0, 16'h00a0, 16'h0012, 3},
		'{16'h0f80, 16'hff30, 16'h0030, 16'h0044, 16'h0044, 16'h0012, 3},
		'{16'hc020, 16'h0000, 16'h0031, 16'h1234, 16'h1234, 16'h0011, 2},
		'{16'h2002, 16'h0000, 16'h0030, 16'h7777, 16'h0013, 16'h0011, 1}};
	ifs_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.mem_rdata_i(rdata), .mem_o(mem), .phase_o(ph), .phase_zero_pulse_o(p0), .phase_seven_pulse_o(p7),
		.chan_tim_o(), .proc_clk_run_o(prun), .chan_clk_run_o(crun), .carry_overflow_flags_o(flags));
	ifs_mem_model mem_u (.clk_i(clk_i), .mem_i(mem), .delay_i(dly), .rdata_o(rdata));
	always #4 clk_i = ~clk_i;
	// phase bookkeeping on the falling edge, where outputs are settled
	always @(negedge clk_i) begin
		clk_n <= clk_n + 1;
		p0_q <= p0;
		if (p0 && !p0_q) begin
			p0_cnt <= p0_cnt + 1;
			p0_dt <= clk_n - p0_t;
			p0_t <= clk_n;
		end
		if (p7) p7_run <= p7_run + 1;
		else if (p7_run != 0) begin
			p7_len <= p7_run;
			p7_run <= 0;
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0000, d};
		// ack and read data are taken at the rising edge that samples ack high
		do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin err_total++; print_verdict(); end
		q = dat_o;
		req <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 16'h0000);
	endtask : rd
	// waits for k machine-cycle starts
	task automatic run(input int k);
		int t;
		t = p0_cnt + k;
		for (int i = 0; i < 1000 * k && p0_cnt < t; i++) @(posedge clk_i);
		if (p0_cnt < t) begin err_total++; print_verdict(); end
	endtask : run
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK(ph, 8'h00)
		`CHK(flags, 2'b00)
		rd(8'hfc);
		`CHK(q, 32'h00000000)
		rd(A_STAT);
		`CHK(q[4:0], 5'h01)
		for (int i = 0; i < 3; i++) wb(1'b1, A_XR1 + 8'(4 * i), 16'(256 * (i + 1)));
		foreach (rows[i]) begin
			mem_u.words[16] = rows[i].w0;
			mem_u.words[17] = rows[i].w1;
			mem_u.words[rows[i].ia[7:0]] = rows[i].w2;
			dly <= i[0] ? 6'd20 : 6'd0;
			wb(1'b1, A_IAR, 16'h0010);
			wb(1'b1, A_CTRL, 16'h0001);
			// stop inside phase 0 of the next fetch, before it touches state
			run(rows[i].n + 1);
			wb(1'b1, A_CTRL, 16'h0000);
			rd(A_ACC);
			`CHK(q[15:0], rows[i].acc)
			rd(A_IAR);
			`CHK(q[15:0], rows[i].iar)
			rd(A_DEC);
			`CHK(q[15:0], rows[i].w0 & 16'hffc0)
			`CHK(mem_u.words[16], rows[i].w0)
			`CHK(mem_u.words[17], rows[i].w1)
			`CHK(mem_u.words[rows[i].ia[7:0]], rows[i].w2)
		end
		`CHK(flags, 2'b10)
		wb(1'b1, A_STEP, 16'h0002);
		mem_u.words[16] = 16'h0805;
		wb(1'b1, A_IAR, 16'h0010);
		wb(1'b1, A_CTRL, 16'h0001);
		run(2);
		wb(1'b1, A_CTRL, 16'h0000);
		`CHK(p7_len, 3 * int'(PH_LEN_S))
		rd(A_ACC);
		`CHK(q[15:0], 16'h0005)
		rd(A_EXT);
		`CHK(q[15:0], 16'h8000)
		wb(1'b1, A_ACC, 16'h1357);
		wb(1'b1, A_XFER, 16'h0001);
		wb(1'b1, A_XFER, 16'h0004);
		wb(1'b1, A_ACC, 16'h0000);
		wb(1'b1, A_XFER, 16'h0002);
		rd(A_ACC);
		`CHK(q[15:0], 16'h1357)
		wb(1'b1, A_ACC, 16'h0000);
		wb(1'b1, A_TMP, 16'hffff);
		wb(1'b1, A_XFER, 16'h0008);
		rd(A_ACC);
		`CHK(q[15:0], 16'h1357)
		for (int s = 0; s < 3; s++) begin
			wb(1'b1, A_CTRL, 16'(4 * s + 1));
			// phase 0 right after start is one clock longer, so time the second full cycle
			run(3);
			`CHK(p0_dt, 8 * int'(s == 0 ? PH_LEN_S : s == 1 ? PH_LEN_M : PH_LEN_L))
			wb(1'b1, A_CTRL, 16'h0000);
		end
		wb(1'b1, A_CTRL, 16'h0003);
		for (n = 0; n < 600 && crun !== 1'b1; n++) @(negedge clk_i);
		`CHK(crun, 1'b1)
		`CHK(prun, 1'b0)
		wb(1'b1, A_CTRL, 16'h0000);
		// reset in mid-run, inside phase 0 while storage is not mid-cycle
		wb(1'b1, A_CTRL, 16'h0001);
		run(2);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK(ph, 8'h00)
		`CHK(prun, 1'b0)
		`CHK(flags, 2'b00)
		rd(A_ACC);
		`CHK(q[15:0], 16'h0000)
		rd(A_STAT);
		`CHK(q[15:0], 16'h0001)
		print_verdict();
	end
endmodule : ifs_seq_bench
